// ---- logic/tweep_target.sv ----
`timescale 1ns/10ps
// Contract
// - SDA changes with SCL high are conditions
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - Acknowledge each received byte on ninth clock
// - Standby at power-up and after stop
// - Address word matches fixed device type
// - Next three bits match strap pins
// - Address LSB selects read or write
// - Match acknowledges, mismatch returns to standby
// - Write inhibit blocks every array write
// - Byte write: address, two words, data
// - Program cycle ignores all inputs
// - Program time counts from stop
// - Page write takes up to 32 bytes
// - Writes increment low five bits, wrap
// - No acknowledge while programming
// - Counter holds last address plus one
// - Reads wrap from top to zero
// - Current read sends byte at counter
// - Controller acknowledge continues sequential read
// - Sample on SCL rise, launch after fall
// - Twelve or thirteen word-address bits used
// - Array holds pages of 32 bytes
module tweep_target #(
  parameter int ADDR_W = tweep_pkg::ADDR_W_DEFAULT,
  parameter int PROG_CYCLES = tweep_pkg::PROG_CYCLES_DEFAULT,
  // Arbitrary neutral device-type code.
  parameter logic [3:0] DEVICE_TYPE = tweep_pkg::DEVICE_TYPE_DEFAULT
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  // Straps and protection
  input wire logic i_chip_select_strap_bit2,
  input wire logic i_chip_select_strap_bit1,
  input wire logic i_chip_select_strap_bit0,
  input wire logic i_write_inhibit,
  // Status
  output logic o_program_busy,
  output logic o_standby
);
  import tweep_pkg::*;

  localparam int MEM_BYTES = 1 << ADDR_W;
  localparam int ROW_W = ADDR_W - PAGE_AW;
  localparam int BUF_W = ADDR_W + BYTE_BITS;

  if (ADDR_W != ADDR_W_SMALL && ADDR_W != ADDR_W_DEFAULT) begin : g_bad_addr
    $error("tweep_target supports twelve or thirteen address bits only");
  end
  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << PROG_CNT_W)) begin : g_bad_prog
    $error("tweep_target program cycle count out of range");
  end

  // Bus pins and straps come from outside this clock domain.
  logic scl_q1, scl_q2, scl_d, sda_q1, sda_q2, sda_d;
  logic [STRAP_W-1:0] strap_q1, strap_q2;
  logic wi_q1, wi_q2;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q1 <= 1'b1;
      scl_q2 <= 1'b1;
      scl_d <= 1'b1;
      sda_q1 <= 1'b1;
      sda_q2 <= 1'b1;
      sda_d <= 1'b1;
      strap_q1 <= '0;
      strap_q2 <= '0;
      wi_q1 <= 1'b0;
      wi_q2 <= 1'b0;
    end else begin
      scl_q1 <= i_scl;
      scl_q2 <= scl_q1;
      scl_d <= scl_q2;
      sda_q1 <= i_sda;
      sda_q2 <= sda_q1;
      sda_d <= sda_q2;
      strap_q1 <= {i_chip_select_strap_bit2, i_chip_select_strap_bit1, i_chip_select_strap_bit0};
      strap_q2 <= strap_q1;
      wi_q1 <= i_write_inhibit;
      wi_q2 <= wi_q1;
    end
  end

  logic scl_rise, scl_fall, start_evt, stop_evt;
  assign scl_rise = scl_q2 & ~scl_d;
  assign scl_fall = ~scl_q2 & scl_d;
  assign start_evt = scl_q2 & scl_d & sda_d & ~sda_q2;
  assign stop_evt = scl_q2 & scl_d & ~sda_d & sda_q2;

  tweep_state_e state, next_state, ack_next, next_ack_next;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shreg, next_shreg, hi, next_hi;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [PROG_CNT_W-1:0] prog_cnt, next_prog_cnt;
  logic host_ack, next_host_ack, sda_oe_n, next_sda_oe_n;
  logic push, commit, clear_page, dev_match;
  logic [15:0] word_addr;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_data [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid, next_page_valid;
  logic [ROW_W-1:0] page_row, next_page_row;
  logic buf_in_ready, buf_out_valid, buf_out_ready;
  logic [BUF_W-1:0] buf_out_data;

  assign dev_match = (shreg[7:4] == DEVICE_TYPE) && (shreg[3:1] == strap_q2);
  assign word_addr = {hi, shreg};

  always_comb begin
    next_state = state;
    next_ack_next = ack_next;
    next_cnt = cnt;
    next_shreg = shreg;
    next_hi = hi;
    next_addr = addr;
    next_prog_cnt = prog_cnt;
    next_host_ack = host_ack;
    next_sda_oe_n = sda_oe_n;
    push = 1'b0;
    commit = 1'b0;
    clear_page = 1'b0;
    case (state)
      S_IDLE: begin
        next_sda_oe_n = 1'b1;
      end
      S_DEV, S_AHI, S_ALO, S_WDAT: begin
        if (scl_rise) begin
          next_shreg = {shreg[6:0], sda_q2};
          next_cnt = cnt + 4'h1;
        end else if (scl_fall && cnt == BIT_CNT_BYTE) begin
          next_cnt = 4'h0;
          next_state = S_ACK;
          next_sda_oe_n = 1'b0;
          case (state)
            S_DEV: begin
              next_ack_next = shreg[0] ? S_RD : S_AHI;
              if (!dev_match) begin
                next_state = S_IDLE;
                next_sda_oe_n = 1'b1;
              end
            end
            S_AHI: begin
              next_hi = shreg;
              next_ack_next = S_ALO;
            end
            S_ALO: begin
              next_addr = word_addr[ADDR_W-1:0];
              next_ack_next = S_WDAT;
            end
            default: begin
              next_ack_next = S_WDAT;
              if (wi_q2 || buf_in_ready) begin
                push = ~wi_q2;
                next_addr = {addr[ADDR_W-1:PAGE_AW], addr[PAGE_AW-1:0] + 5'h01};
              end else begin
                // A full buffer refuses the byte rather than lose it.
                next_state = S_IDLE;
                next_sda_oe_n = 1'b1;
              end
            end
          endcase
        end
      end
      S_ACK: begin
        if (scl_fall) begin
          next_sda_oe_n = 1'b1;
          next_cnt = 4'h0;
          if (ack_next == S_RD) begin
            next_shreg = mem[addr];
            next_addr = addr + 1'b1;
            next_sda_oe_n = mem[addr][7];
            next_state = S_RD;
          end else begin
            next_state = ack_next;
          end
        end
      end
      S_RD: begin
        if (scl_rise) begin
          next_cnt = cnt + 4'h1;
        end else if (scl_fall) begin
          if (cnt == BIT_CNT_BYTE) begin
            next_sda_oe_n = 1'b1;
            next_state = S_MACK;
          end else begin
            next_shreg = {shreg[6:0], 1'b0};
            next_sda_oe_n = shreg[6];
          end
        end
      end
      S_MACK: begin
        if (scl_rise) begin
          next_host_ack = ~sda_q2;
        end else if (scl_fall) begin
          next_cnt = 4'h0;
          if (host_ack) begin
            next_shreg = mem[addr];
            next_addr = addr + 1'b1;
            next_sda_oe_n = mem[addr][7];
            next_state = S_RD;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_PROG: begin
        next_sda_oe_n = 1'b1;
        if (prog_cnt == '0 && !buf_out_valid) begin
          commit = 1'b1;
          next_state = S_IDLE;
        end else if (prog_cnt != '0) begin
          next_prog_cnt = prog_cnt - 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_sda_oe_n = 1'b1;
      end
    endcase
    // Conditions override any bit in flight, so a stuck bus recovers on a start.
    if (state != S_PROG) begin
      if (start_evt) begin
        next_state = S_DEV;
        next_cnt = 4'h0;
        next_sda_oe_n = 1'b1;
        clear_page = 1'b1;
      end else if (stop_evt) begin
        next_sda_oe_n = 1'b1;
        next_prog_cnt = PROG_CNT_W'(PROG_CYCLES - 1);
        next_state = (page_valid != '0 || buf_out_valid) ? S_PROG : S_IDLE;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= S_IDLE;
      ack_next <= S_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      hi <= 8'h00;
      addr <= '0;
      prog_cnt <= '0;
      host_ack <= 1'b0;
      sda_oe_n <= 1'b1;
      o_sda_o <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_program_busy <= 1'b0;
      o_standby <= 1'b1;
    end else begin
      state <= next_state;
      ack_next <= next_ack_next;
      cnt <= next_cnt;
      shreg <= next_shreg;
      hi <= next_hi;
      addr <= next_addr;
      prog_cnt <= next_prog_cnt;
      host_ack <= next_host_ack;
      sda_oe_n <= next_sda_oe_n;
      o_sda_o <= 1'b0;
      o_sda_oe_n <= next_sda_oe_n;
      o_program_busy <= (next_state == S_PROG);
      o_standby <= (next_state == S_IDLE);
    end
  end

  // The program cycle holds the drain off only in its commit cycle.
  assign buf_out_ready = ~commit;

  tweep_buffer #(
    .WIDTH(BUF_W),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .i_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(push),
    .o_in_ready(buf_in_ready),
    .i_in_data({addr, shreg}),
    .o_out_valid(buf_out_valid),
    .i_out_ready(buf_out_ready),
    .o_out_data(buf_out_data)
  );

  always_comb begin
    next_page_valid = page_valid;
    next_page_row = page_row;
    if (commit || clear_page) begin
      next_page_valid = '0;
    end else if (buf_out_valid) begin
      next_page_valid[buf_out_data[BYTE_BITS +: PAGE_AW]] = 1'b1;
      next_page_row = buf_out_data[BUF_W-1 -: ROW_W];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      page_valid <= '0;
      page_row <= '0;
    end else begin
      page_valid <= next_page_valid;
      page_row <= next_page_row;
    end
  end

  // Array and page latch are data, not control, and carry no reset.
  always_ff @(posedge i_ref_clk) begin
    if (buf_out_valid && buf_out_ready) begin
      page_data[buf_out_data[BYTE_BITS +: PAGE_AW]] <= buf_out_data[BYTE_BITS-1:0];
    end
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_valid[i]) begin
          mem[{page_row, PAGE_AW'(i)}] <= page_data[i];
        end
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence byte_end_s;
    scl_fall && cnt == BIT_CNT_BYTE && !start_evt && !stop_evt;
  endsequence
  sequence dev_word_s;
    state == S_DEV ##0 byte_end_s;
  endsequence

  dev_ack_a: assert property (dev_word_s ##0 dev_match |=> state == S_ACK && !o_sda_oe_n)
    else $error("matching address not acknowledged");
  dev_nack_a: assert property (dev_word_s ##0 !dev_match |=> state == S_IDLE && o_sda_oe_n)
    else $error("mismatching address not released");
  ack_release_a: assert property (state == S_ACK && scl_fall && ack_next != S_RD |=> o_sda_oe_n)
    else $error("acknowledge held past ninth clock");
  start_seen_a: assert property (start_evt && state != S_PROG |=> state == S_DEV && cnt == 4'h0)
    else $error("start not recognised");
  stop_read_a: assert property (stop_evt && state inside {S_RD, S_MACK} |=> o_standby)
    else $error("stop after read did not reach standby");
  prog_quiet_a: assert property (state == S_PROG |-> o_sda_oe_n && o_program_busy)
    else $error("bus driven during program cycle");
  prog_start_a: assert property ($rose(o_program_busy) |-> prog_cnt == PROG_CNT_W'(PROG_CYCLES - 1))
    else $error("program count not loaded at stop");
  prog_end_a: assert property (state == S_PROG && prog_cnt == '0 && !buf_out_valid
                               |=> state == S_IDLE && o_standby)
    else $error("program cycle did not end on time");
  page_wrap_a: assert property (push && addr[PAGE_AW-1:0] == 5'h1F |=> addr[PAGE_AW-1:0] == 5'h00
                                && addr[ADDR_W-1:PAGE_AW] == $past(addr[ADDR_W-1:PAGE_AW]))
    else $error("page address did not wrap in page");
  read_wrap_a: assert property (state == S_MACK && scl_fall && host_ack && !start_evt && !stop_evt
                                && addr == '1 |=> addr == '0)
    else $error("read counter did not wrap to zero");
  inhibit_a: assert property (wi_q2 |-> !push)
    else $error("write accepted while inhibited");
  launch_a: assert property ($changed(o_sda_oe_n) |-> $past(scl_fall || start_evt || stop_evt)
                             || $past(state == S_IDLE))
    else $error("data launched away from a falling clock");

endmodule : tweep_target

// ---- inc/tweep_pkg.sv ----
package tweep_pkg;

  localparam int BYTE_BITS = 8;
  localparam int STRAP_W = 3;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_AW = 5;
  localparam int ADDR_W_SMALL = 12;
  localparam int ADDR_W_DEFAULT = 13;
  localparam int BUF_DEPTH = 2;
  localparam int PROG_CNT_W = 20;

  // Device-type code is an arbitrary neutral value.
  localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h6;

  localparam int CLK_PERIOD_NS = 40;
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int PROGRAM_CYCLE_TIME_NS = PROGRAM_CYCLE_TIME_MS * 1000000;
  // A longest time rounds down to whole cycles.
  localparam int PROG_CYCLES_DEFAULT = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;

  localparam logic [3:0] BIT_CNT_BYTE = 4'h8;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_DEV  = 4'b0001,
    S_AHI  = 4'b0010,
    S_ALO  = 4'b0011,
    S_WDAT = 4'b0100,
    S_ACK  = 4'b0101,
    S_RD   = 4'b0110,
    S_MACK = 4'b0111,
    S_PROG = 4'b1000
  } tweep_state_e;

endpackage : tweep_pkg

// ---- logic/tweep_buffer.sv ----
`timescale 1ns/10ps
module tweep_buffer #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("tweep_buffer depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] entry [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic [PW:0] next_wr_ptr;
  logic [PW:0] next_rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) && (wr_ptr[PW] != rd_ptr[PW]);
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data = entry[rd_ptr[PW-1:0]];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (i_in_valid && !full) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (i_out_ready && !empty) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage carries no reset; only the pointers say what is valid.
  always_ff @(posedge i_clk) begin
    if (i_in_valid && !full) begin
      entry[wr_ptr[PW-1:0]] <= i_in_data;
    end
  end

endmodule : tweep_buffer

// ---- dv/tweep_ctrl_model.sv ----
`timescale 1ns/10ps
// Bus controller stand-in. SCL rests high between frames and SDA is only ever pulled low.
module tweep_ctrl_model (
  // Bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  localparam time Q = 80ns;

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Serves as a first or a repeated start.
  task automatic start();
    o_sda_low = 1'b0;
    #Q;
    o_scl = 1'b1;
    #(2 * Q);
    o_sda_low = 1'b1;
    #(2 * Q);
    o_scl = 1'b0;
  endtask : start

  task automatic stop();
    #Q;
    o_sda_low = 1'b1;
    #Q;
    o_scl = 1'b1;
    #(2 * Q);
    o_sda_low = 1'b0;
    #(2 * Q);
  endtask : stop

  // Sampling late in the high phase gives the target time to launch its bit.
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      #Q;
      o_sda_low = !tx[i];
      #Q;
      o_scl = 1'b1;
      #(2 * Q - 10ns);
      rx[i] = i_sda;
      #10ns;
      o_scl = 1'b0;
    end
    q = rx[8:1];
    ack = rx[0];
  endtask : xfer

  // Eight read clocks with SDA released; the ninth clock is left to the caller.
  task automatic rd8(output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      #Q;
      o_sda_low = 1'b0;
      #Q;
      o_scl = 1'b1;
      #(2 * Q - 10ns);
      q[i] = i_sda;
      #10ns;
      o_scl = 1'b0;
    end
  endtask : rd8

  // Clocks SCL until SDA reads high in a high phase, nine times at most, then starts.
  // The low phase stays as long as in a transfer so the target never moves SDA with SCL high.
  task automatic recover();
    o_sda_low = 1'b0;
    for (int i = 0; i < 9; i++) begin
      #(2 * Q);
      o_scl = 1'b1;
      #(2 * Q);
      if (i_sda === 1'b1) begin
        break;
      end
      o_scl = 1'b0;
    end
    start();
  endtask : recover
endmodule : tweep_ctrl_model

// ---- dv/tweep_target_tb_top.sv ----
`timescale 1ns/10ps
module tweep_target_tb_top;
  import tweep_pkg::*;
  localparam int PROG = 400;
  logic clk;
  logic rst_n;
  logic scl;
  logic sda;
  logic ctl_low;
  logic sda_o;
  logic oe_n;
  logic wi;
  logic busy;
  logic stby;
  logic [2:0] strap;
  logic [7:0] q;
  logic a;
  logic [7:0] mem [int];
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;

  // Pull-up on the shared data line.
  assign sda = ctl_low ? 1'b0 : (oe_n === 1'b0 ? sda_o : 1'b1);

  tweep_target #(.ADDR_W(13), .PROG_CYCLES(PROG)) tweep_target_inst (
    .i_ref_clk(clk),
    .i_reset_n(rst_n),
    .i_scl(scl),
    .i_sda(sda),
    .o_sda_o(sda_o),
    .o_sda_oe_n(oe_n),
    .i_chip_select_strap_bit2(strap[2]),
    .i_chip_select_strap_bit1(strap[1]),
    .i_chip_select_strap_bit0(strap[0]),
    .i_write_inhibit(wi),
    .o_program_busy(busy),
    .o_standby(stby)
  );

  tweep_ctrl_model tweep_ctrl_model_inst (
    .i_sda(sda),
    .o_scl(scl),
    .o_sda_low(ctl_low)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      chk(8'h00, 8'h01);
      results();
    end
  end

  function automatic logic [7:0] dev(input logic rd);
    return {DEVICE_TYPE_DEFAULT, strap, rd};
  endfunction : dev

  function automatic logic [12:0] wr_next(input logic [12:0] w);
    return {w[12:5], w[4:0] + 5'h01};
  endfunction : wr_next

  task automatic wr(input logic [7:0] d, input logic exp_ack);
    tweep_ctrl_model_inst.xfer(d, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, exp_ack});
  endtask : wr

  task automatic hdr(input logic [15:0] wa);
    tweep_ctrl_model_inst.start();
    wr(dev(1'b0), 1'b0);
    wr(wa[15:8], 1'b0);
    wr(wa[7:0], 1'b0);
  endtask : hdr

  // Dummy write, repeated start, then n reads with the last one left unacknowledged.
  task automatic rrd(input logic [15:0] wa, input int n);
    logic [12:0] ra;
    ra = wa[12:0];
    hdr(wa);
    tweep_ctrl_model_inst.start();
    wr(dev(1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      tweep_ctrl_model_inst.xfer(8'hFF, (i == n - 1), q, a);
      chk(q, mem[ra]);
      ra = ra + 13'h0001;
    end
    tweep_ctrl_model_inst.stop();
  endtask : rrd

  // The first polls land inside the program cycle and must be refused.
  task automatic wait_prog();
    int polls;
    repeat (2) @(posedge clk);
    chk({7'h00, busy}, 8'h01);
    polls = 0;
    a = 1'b1;
    while (a !== 1'b0 && polls < 20) begin
      tweep_ctrl_model_inst.start();
      tweep_ctrl_model_inst.xfer(dev(1'b0), 1'b1, q, a);
      if (polls == 0) chk({7'h00, a}, 8'h01);
      tweep_ctrl_model_inst.stop();
      polls++;
    end
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, a}, 8'h00);
    chk({7'h00, polls >= 5 && polls <= 6}, 8'h01);
  endtask : wait_prog

  initial begin
    logic [12:0] w;
    logic [7:0] d;
    rst_n = 1'b0;
    wi = 1'b0;
    strap = 3'h0;
    void'($urandom(6));
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({5'h00, stby, busy, oe_n}, 8'h05);
    strap = 3'($urandom);
    repeat (4) @(posedge clk);
    // Location zero is written first so the read wrap later has a known target.
    d = 8'($urandom);
    hdr(16'h0000);
    wr(d, 1'b0);
    tweep_ctrl_model_inst.stop();
    mem[0] = d;
    wait_prog();
    // Start two bytes before the page end and send two bytes more than a page.
    hdr(16'hFFFE);
    w = 13'h1FFE;
    for (int i = 0; i < 34; i++) begin
      d = 8'($urandom);
      wr(d, 1'b0);
      mem[w] = d;
      w = wr_next(w);
    end
    tweep_ctrl_model_inst.stop();
    wait_prog();
    rrd(16'hFFE0, 32);
    // The counter has passed the top of the array and must point at zero.
    tweep_ctrl_model_inst.start();
    wr(dev(1'b1), 1'b0);
    tweep_ctrl_model_inst.xfer(8'hFF, 1'b1, q, a);
    chk(q, mem[0]);
    tweep_ctrl_model_inst.stop();
    repeat (2) @(posedge clk);
    chk({7'h00, stby}, 8'h01);
    // A stop in the ninth clock of a read must still return the target to standby.
    hdr(16'h0000);
    tweep_ctrl_model_inst.start();
    wr(dev(1'b1), 1'b0);
    tweep_ctrl_model_inst.rd8(q);
    chk(q, mem[0]);
    tweep_ctrl_model_inst.stop();
    repeat (2) @(posedge clk);
    chk({7'h00, stby}, 8'h01);
    // A read cut short before its first clock is cleared by clocking until SDA is free, then a start.
    hdr(16'h0000);
    tweep_ctrl_model_inst.start();
    wr(dev(1'b1), 1'b0);
    tweep_ctrl_model_inst.recover();
    wr(dev(1'b0), 1'b0);
    tweep_ctrl_model_inst.stop();
    repeat (2) @(posedge clk);
    chk({7'h00, stby}, 8'h01);
    // An inhibited write is acknowledged but leaves the array and busy flag alone.
    #1;
    wi = 1'b1;
    hdr(16'h0000);
    wr(~mem[0], 1'b0);
    tweep_ctrl_model_inst.stop();
    repeat (2) @(posedge clk);
    chk({7'h00, busy}, 8'h00);
    #1;
    wi = 1'b0;
    rrd(16'h1FFF, 2);
    for (int b = 1; b < 8; b++) begin
      tweep_ctrl_model_inst.start();
      wr(dev(1'b0) ^ 8'(1 << b), 1'b1);
      chk({6'h00, stby, oe_n}, 8'h03);
      wr(8'h00, 1'b1);
      tweep_ctrl_model_inst.stop();
    end
    results();
  end
endmodule : tweep_target_tb_top
